// File: hdl/eba_pkg.sv
// Purpose: Shared types and constants for the 8-bit subtract/logic/compare datapath
// Assumes: One instruction clock equals one mclk period
// Notes:   Clock and byte counts per operand form live here; the bench works out its own copy

package eba_pkg;

   // ----------------------------------------------------------------
   // Operations and operand forms
   // ----------------------------------------------------------------
   typedef enum logic [2:0]
   {
      EBA_OP_SUB = 3'h0,
      EBA_OP_SUBTRACT_BORROW_OP = 3'h1,
      EBA_OP_AND = 3'h2,
      EBA_OP_OR = 3'h3,
      EBA_OP_XOR = 3'h4,
      EBA_OP_CMP = 3'h5
   } eba_op_t;

   typedef enum logic [3:0]
   {
      EBA_FORM_A_IMM = 4'h0,      // Accumulator, immediate byte
      EBA_FORM_SADDR_IMM = 4'h1,  // Short direct address, immediate byte
      EBA_FORM_A_REG = 4'h2,      // Accumulator, general register
      EBA_FORM_REG_A = 4'h3,      // General register, accumulator
      EBA_FORM_A_SADDR = 4'h4,    // Accumulator, short direct address
      EBA_FORM_A_ABS = 4'h5,      // Accumulator, absolute_address
      EBA_FORM_A_PTR = 4'h6,      // Accumulator, pointer_pair indirect
      EBA_FORM_A_PTR_BYTE = 4'h7, // Pointer pair plus immediate byte
      EBA_FORM_A_PTR_B = 4'h8,    // Pointer pair plus register B
      EBA_FORM_A_PTR_C = 4'h9     // Pointer pair plus register C
   } eba_form_t;

   typedef enum logic [1:0]
   {
      EBA_ST_IDLE = 2'b01,
      EBA_ST_RUN = 2'b10
   } eba_state_t;

   // ----------------------------------------------------------------
   // Widths, reset values, register index
   // ----------------------------------------------------------------
   localparam int EBA_DW = 8;
   localparam int EBA_CW = 5;
   localparam logic [2:0] EBA_REG_IDX_ACC = 3'h1;
   localparam logic [7:0] EBA_RESULT_RST = 8'h00;
   localparam logic EBA_FLAG_RST = 1'b0;
   localparam logic [1:0] EBA_SYNC_RST = 2'h0;
   localparam logic [4:0] EBA_CNT_RST = 5'h00;
   localparam logic [1:0] EBA_BYTES_RST = 2'h0;

   // ----------------------------------------------------------------
   // Byte counts
   // ----------------------------------------------------------------
   localparam logic [1:0] EBA_BYTES_ONE = 2'h1;
   localparam logic [1:0] EBA_BYTES_TWO = 2'h2;
   localparam logic [1:0] EBA_BYTES_THREE = 2'h3;

   // ----------------------------------------------------------------
   // Clock counts: fast column is high-speed RAM or no data access
   // ----------------------------------------------------------------
   localparam logic [4:0] EBA_CLK_SHORT = 5'h04;
   localparam logic [4:0] EBA_CLK_SADDR_IMM_FAST = 5'h06;
   localparam logic [4:0] EBA_CLK_SADDR_IMM_SLOW = 5'h08;
   localparam logic [4:0] EBA_CLK_A_SADDR_SLOW = 5'h05;
   localparam logic [4:0] EBA_CLK_LONG_FAST = 5'h08;
   localparam logic [4:0] EBA_CLK_LONG_SLOW = 5'h09;
   localparam logic [4:0] EBA_CLK_PTR_SLOW = 5'h05;

endpackage : eba_pkg

// File: hdl/eba_op_unit.sv
// Purpose: Combinational 8-bit subtract and logic unit with flag results
// Assumes: Carry input is the current carry flag
// Notes:   Caller decides which flags are kept

module eba_op_unit
(
   input wire eba_pkg::eba_op_t op,
   input wire logic [7:0] opa,
   input wire logic [7:0] opb,
   input wire logic cin,
   output logic [7:0] res,
   output logic borrow,
   output logic half_borrow,
   output logic is_zero
);

   logic [8:0] diff;
   logic [4:0] low_diff;
   logic bin;

   // ----------------------------------------------------------------
   // Arithmetic and logic
   // ----------------------------------------------------------------
   // Borrow in only for subtract with borrow
   always_comb
   begin
      bin = (op == eba_pkg::EBA_OP_SUBTRACT_BORROW_OP) ? cin : 1'b0;
      diff = {1'b0, opa} - {1'b0, opb} - {8'h00, bin};
      low_diff = {1'b0, opa[3:0]} - {1'b0, opb[3:0]} - {4'h0, bin};
      borrow = diff[8];
      half_borrow = low_diff[4];
      case (op)
         eba_pkg::EBA_OP_AND: res = opa & opb;
         eba_pkg::EBA_OP_OR: res = opa | opb;
         eba_pkg::EBA_OP_XOR: res = opa ^ opb;
         default: res = diff[7:0];
      endcase
      is_zero = (res == 8'h00);
   end

endmodule : eba_op_unit

// File: hdl/eba_alu.sv
// Purpose: Sequenced 8-bit subtract, logic and compare execution with timing
// Assumes: mclk is the CPU clock picked by processor_clock_select_reg
// Notes:   Operand fetch and write-back are done by the core's access path
//
// Functional notes
// RULE1: One instruction clock is one mclk period
// RULE2: Counts are for internal ROM programs
// RULE3: Non high-speed RAM data uses slow column
// RULE4: High-speed RAM or no access uses fast
// RULE5: External reads add configured read waits
// RULE6: Accumulator immediate: 2 bytes, 4 clocks
// RULE7: Short direct immediate: 3 bytes, 6/8 clocks
// RULE8: Register forms 2 bytes, 4 clocks, r not A; only the accumulator-first form is refused
// RULE9: Accumulator short direct: 2 bytes, 4/5 clocks
// RULE10: Absolute source: 3 bytes, 8/9+n clocks
// RULE11: Pointer indirect: 1 byte, 4/5+n clocks
// RULE12: Indexed indirect: 2 bytes, 8/9+n clocks
// RULE13: Subtract stores difference, borrow to carry
// RULE14: Subtract with borrow also subtracts carry
// RULE15: AND updates zero flag only
// RULE16: OR updates zero flag only
// RULE17: XOR updates zero flag only
// RULE18: Compare sets flags, writes nothing

module eba_alu
(
   input wire logic mclk,
   input wire logic resetn,
   input wire logic start,
   input wire eba_pkg::eba_op_t op,
   input wire eba_pkg::eba_form_t form,
   input wire logic [2:0] reg_sel,
   input wire logic [7:0] first_operand,
   input wire logic [7:0] second_operand,
   input wire logic data_in_hram,
   input wire logic [3:0] read_waits,
   output logic busy,
   output logic done,
   output logic illegal_q,
   output logic [7:0] result_q,
   output logic write_back_q,
   output logic carry_flag_q,
   output logic aux_carry_flag_q,
   output logic zero_flag_q,
   output logic [1:0] instr_bytes_q,
   output logic [4:0] instr_clocks_q
);

   // ----------------------------------------------------------------
   // Decode functions
   // ----------------------------------------------------------------
   // Instruction length in bytes
   function automatic logic [1:0] fn_bytes(input eba_pkg::eba_form_t f);
      case (f)
         eba_pkg::EBA_FORM_A_PTR: fn_bytes = eba_pkg::EBA_BYTES_ONE; // [RULE11]
         eba_pkg::EBA_FORM_SADDR_IMM,
         eba_pkg::EBA_FORM_A_ABS: fn_bytes = eba_pkg::EBA_BYTES_THREE; // [RULE7] [RULE10]
         default: fn_bytes = eba_pkg::EBA_BYTES_TWO; // [RULE6] [RULE8] [RULE9] [RULE12]
      endcase
   endfunction : fn_bytes

   // Forms whose data read may land in the external expansion area
   function automatic logic fn_ext_read(input eba_pkg::eba_form_t f);
      case (f)
         eba_pkg::EBA_FORM_A_ABS,
         eba_pkg::EBA_FORM_A_PTR,
         eba_pkg::EBA_FORM_A_PTR_BYTE,
         eba_pkg::EBA_FORM_A_PTR_B,
         eba_pkg::EBA_FORM_A_PTR_C: fn_ext_read = 1'b1;
         default: fn_ext_read = 1'b0;
      endcase
   endfunction : fn_ext_read

   // Clock count; slow column only when the data is not in high-speed RAM
   function automatic logic [4:0] fn_clocks(input eba_pkg::eba_form_t f, input logic hram,
                                            input logic [3:0] waits);
      logic [4:0] base;
      base = eba_pkg::EBA_CLK_SHORT;
      case (f)
         eba_pkg::EBA_FORM_SADDR_IMM:
            base = hram ? eba_pkg::EBA_CLK_SADDR_IMM_FAST
                        : eba_pkg::EBA_CLK_SADDR_IMM_SLOW; // [RULE7] [RULE3] [RULE4]
         eba_pkg::EBA_FORM_A_SADDR:
            base = hram ? eba_pkg::EBA_CLK_SHORT
                        : eba_pkg::EBA_CLK_A_SADDR_SLOW; // [RULE9]
         eba_pkg::EBA_FORM_A_PTR:
            base = hram ? eba_pkg::EBA_CLK_SHORT
                        : eba_pkg::EBA_CLK_PTR_SLOW; // [RULE11]
         eba_pkg::EBA_FORM_A_ABS,
         eba_pkg::EBA_FORM_A_PTR_BYTE,
         eba_pkg::EBA_FORM_A_PTR_B,
         eba_pkg::EBA_FORM_A_PTR_C:
            base = hram ? eba_pkg::EBA_CLK_LONG_FAST
                        : eba_pkg::EBA_CLK_LONG_SLOW; // [RULE10] [RULE12]
         default:
            base = eba_pkg::EBA_CLK_SHORT; // No data access: fast column [RULE4] [RULE6] [RULE8]
      endcase
      // Read waits stretch only external reads [RULE5]
      if (!hram && fn_ext_read(f))
         fn_clocks = base + {1'b0, waits};
      else
         fn_clocks = base;
   endfunction : fn_clocks

   // ----------------------------------------------------------------
   // Reset release
   // ----------------------------------------------------------------
   logic [1:0] rst_sync_q;
   logic rst_n_q;

   // Two-stage release so all state leaves reset on one edge
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
         rst_sync_q <= eba_pkg::EBA_SYNC_RST;
      else
         rst_sync_q <= {rst_sync_q[0], 1'b1};
   end
   assign rst_n_q = rst_sync_q[1];

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   eba_pkg::eba_state_t state_q, state_d;
   logic [4:0] cnt_q, cnt_d;
   logic [4:0] clocks_d;
   logic [1:0] bytes_d;
   logic bad_reg;
   logic accept;
   logic illegal_d;

   // Accumulator-first register form may not name the accumulator [RULE8]
   assign bad_reg = (form == eba_pkg::EBA_FORM_A_REG) && (reg_sel == eba_pkg::EBA_REG_IDX_ACC);
   assign busy = (state_q == eba_pkg::EBA_ST_RUN);
   assign accept = start && !busy && !bad_reg;
   // Last instruction clock of the instruction
   assign done = busy && (cnt_q == eba_pkg::EBA_CNT_RST);

   // Next state; each mclk is one instruction clock [RULE1] [RULE2]
   always_comb
   begin
      state_d = state_q;
      cnt_d = cnt_q;
      clocks_d = instr_clocks_q;
      bytes_d = instr_bytes_q;
      illegal_d = start && !busy && bad_reg;
      case (state_q)
         eba_pkg::EBA_ST_IDLE:
         begin
            if (accept)
            begin
               clocks_d = fn_clocks(form, data_in_hram, read_waits);
               bytes_d = fn_bytes(form);
               cnt_d = clocks_d - 5'h01;
               state_d = eba_pkg::EBA_ST_RUN;
            end
         end
         eba_pkg::EBA_ST_RUN:
         begin
            if (done)
               state_d = eba_pkg::EBA_ST_IDLE;
            else
               cnt_d = cnt_q - 5'h01;
         end
         default:
         begin
            state_d = eba_pkg::EBA_ST_IDLE;
            cnt_d = eba_pkg::EBA_CNT_RST;
         end
      endcase
   end

   // Sequencer registers
   always_ff @(posedge mclk or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         state_q <= eba_pkg::EBA_ST_IDLE;
         cnt_q <= eba_pkg::EBA_CNT_RST;
         instr_clocks_q <= eba_pkg::EBA_CNT_RST;
         instr_bytes_q <= eba_pkg::EBA_BYTES_RST;
         illegal_q <= eba_pkg::EBA_FLAG_RST;
      end
      else
      begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         instr_clocks_q <= clocks_d;
         instr_bytes_q <= bytes_d;
         illegal_q <= illegal_d;
      end
   end

   // ----------------------------------------------------------------
   // Operand capture and result
   // ----------------------------------------------------------------
   eba_pkg::eba_op_t op_q, op_d;
   logic [7:0] opa_q, opa_d;
   logic [7:0] opb_q, opb_d;
   logic [7:0] unit_res;
   logic unit_borrow;
   logic unit_half;
   logic unit_zero;
   logic [7:0] result_d;
   logic write_back_d;
   logic carry_d;
   logic aux_d;
   logic zero_d;
   logic arith_op;

   // Operands are held so the core may change its inputs while busy
   always_comb
   begin
      op_d = accept ? op : op_q;
      opa_d = accept ? first_operand : opa_q;
      opb_d = accept ? second_operand : opb_q;
   end

   eba_op_unit u_op
   (
      .op(op_q),
      .opa(opa_q),
      .opb(opb_q),
      .cin(carry_flag_q),
      .res(unit_res),
      .borrow(unit_borrow),
      .half_borrow(unit_half),
      .is_zero(unit_zero)
   );

   assign arith_op = (op_q == eba_pkg::EBA_OP_SUB) ||
                     (op_q == eba_pkg::EBA_OP_SUBTRACT_BORROW_OP) ||
                     (op_q == eba_pkg::EBA_OP_CMP);

   // Flags and result change only on the last instruction clock
   always_comb
   begin
      result_d = result_q;
      write_back_d = 1'b0;
      carry_d = carry_flag_q;
      aux_d = aux_carry_flag_q;
      zero_d = zero_flag_q;
      if (done)
      begin
         zero_d = unit_zero; // [RULE13] [RULE15] [RULE16] [RULE17]
         if (arith_op)
         begin
            carry_d = unit_borrow; // [RULE13] [RULE14] [RULE18]
            aux_d = unit_half;
         end
         // Compare leaves the destination untouched [RULE18]
         if (op_q != eba_pkg::EBA_OP_CMP)
         begin
            result_d = unit_res; // [RULE13] [RULE14]
            write_back_d = 1'b1;
         end
      end
   end

   // Datapath registers
   always_ff @(posedge mclk or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         op_q <= eba_pkg::EBA_OP_SUB;
         opa_q <= eba_pkg::EBA_RESULT_RST;
         opb_q <= eba_pkg::EBA_RESULT_RST;
         result_q <= eba_pkg::EBA_RESULT_RST;
         write_back_q <= eba_pkg::EBA_FLAG_RST;
         carry_flag_q <= eba_pkg::EBA_FLAG_RST;
         aux_carry_flag_q <= eba_pkg::EBA_FLAG_RST;
         zero_flag_q <= eba_pkg::EBA_FLAG_RST;
      end
      else
      begin
         op_q <= op_d;
         opa_q <= opa_d;
         opb_q <= opb_d;
         result_q <= result_d;
         write_back_q <= write_back_d;
         carry_flag_q <= carry_d;
         aux_carry_flag_q <= aux_d;
         zero_flag_q <= zero_d;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n_q);

   property p_imm_time;
      accept && form == eba_pkg::EBA_FORM_A_IMM |-> !done [*4] ##1 done;
   endproperty
   a_imm_time: assert property (p_imm_time) else $error("Immediate form not 4 clocks"); // [RULE6]

   property p_saddr_imm_time;
      accept && form == eba_pkg::EBA_FORM_SADDR_IMM && !data_in_hram
         |-> ##8 done ##1 instr_bytes_q == eba_pkg::EBA_BYTES_THREE;
   endproperty
   a_saddr_imm_time: assert property (p_saddr_imm_time) else $error("Short imm slow wrong"); // [RULE7]

   property p_bad_reg;
      start && !busy && bad_reg |=> illegal_q && !busy;
   endproperty
   a_bad_reg: assert property (p_bad_reg) else $error("Register A form not refused"); // [RULE8]

   property p_a_saddr_time;
      accept && form == eba_pkg::EBA_FORM_A_SADDR && !data_in_hram |-> ##5 done;
   endproperty
   a_a_saddr_time: assert property (p_a_saddr_time) else $error("Short direct not 5 clocks"); // [RULE9]

   property p_abs_hram;
      accept && form == eba_pkg::EBA_FORM_A_ABS && data_in_hram |-> ##8 done;
   endproperty
   a_abs_hram: assert property (p_abs_hram) else $error("Absolute fast not 8 clocks"); // [RULE10]

   property p_ptr_waits;
      accept && form == eba_pkg::EBA_FORM_A_PTR && !data_in_hram && read_waits == 4'h3
         |=> busy [*8] ##1 !busy;
   endproperty
   a_ptr_waits: assert property (p_ptr_waits) else $error("Pointer wait stretch wrong"); // [RULE11]

   property p_idx_waits;
      accept && form == eba_pkg::EBA_FORM_A_PTR_B && !data_in_hram && read_waits == 4'h2
         |-> ##11 done;
   endproperty
   a_idx_waits: assert property (p_idx_waits) else $error("Indexed wait stretch wrong"); // [RULE12]

   property p_logic_keeps;
      done && (op_q == eba_pkg::EBA_OP_AND || op_q == eba_pkg::EBA_OP_XOR)
         |=> carry_flag_q == $past(carry_flag_q) && aux_carry_flag_q == $past(aux_carry_flag_q)
             && zero_flag_q == (result_q == 8'h00);
   endproperty
   a_logic_keeps: assert property (p_logic_keeps) else $error("Logic op touched carry"); // [RULE15]

   property p_cmp_no_write;
      done && op_q == eba_pkg::EBA_OP_CMP
         |=> !write_back_q && result_q == $past(result_q)
             && carry_flag_q == ($past(opa_q) < $past(opb_q));
   endproperty
   a_cmp_no_write: assert property (p_cmp_no_write) else $error("Compare wrote result"); // [RULE18]

   property p_sub_value;
      done && op_q == eba_pkg::EBA_OP_SUB
         |=> write_back_q && result_q == 8'($past(opa_q) - $past(opb_q))
             && carry_flag_q == ($past(opa_q) < $past(opb_q));
   endproperty
   a_sub_value: assert property (p_sub_value) else $error("Subtract result wrong"); // [RULE13]

endmodule : eba_alu

// File: verification/eba_core_model.sv
// Purpose: Sequencer side that issues one instruction at a time
// Assumes: Requests change at the falling edge of mclk
// Notes:   Operands are inverted once taken, so a late sample shows

module eba_core_model
(
   input wire logic mclk,
   input wire logic busy,
   input wire logic done,
   output logic start,
   output eba_pkg::eba_op_t op,
   output eba_pkg::eba_form_t form,
   output logic [2:0] reg_sel,
   output logic [7:0] first_operand,
   output logic [7:0] second_operand,
   output logic data_in_hram,
   output logic [3:0] read_waits
);
   timeunit 1ns;
   timeprecision 1ns;

   // Idle values at time zero
   initial
   begin
      start = 1'b0;
      op = eba_pkg::EBA_OP_SUB;
      form = eba_pkg::EBA_FORM_A_IMM;
      reg_sel = 3'h2;
      first_operand = 8'h00;
      second_operand = 8'h00;
      data_in_hram = 1'b1;
      read_waits = 4'h0;
   end

   // Present one request; start rises in this time step
   task automatic load(input eba_pkg::eba_op_t o, input eba_pkg::eba_form_t f,
      input logic [2:0] r, input logic [7:0] a, input logic [7:0] b,
      input logic h, input logic [3:0] n);
      op = o;
      form = f;
      reg_sel = r;
      first_operand = a;
      second_operand = b;
      data_in_hram = h;
      read_waits = n;
      start = 1'b1;
   endtask : load

   // Hold start for one edge, then drop it and scramble the operands
   task automatic release_req();
      @(negedge mclk);
      start = 1'b0;
      first_operand = ~first_operand;
      second_operand = ~second_operand;
   endtask : release_req

   // Issue and count instruction clocks up to done; 0 means none came
   task automatic issue(input eba_pkg::eba_op_t o, input eba_pkg::eba_form_t f,
      input logic [2:0] r, input logic [7:0] a, input logic [7:0] b,
      input logic h, input logic [3:0] n, output int t);
      load(o, f, r, a, b, h, n);
      release_req();
      t = 0;
      for (int k = 1; k <= 40 && t == 0; k++)
      begin
         if (done === 1'b1)
            t = k;
         else
            @(negedge mclk);
      end
   endtask : issue

   // Single-edge request with no wait for an answer
   task automatic pulse(input eba_pkg::eba_op_t o, input eba_pkg::eba_form_t f,
      input logic [2:0] r);
      load(o, f, r, 8'h00, 8'h00, 1'b1, 4'h0);
      release_req();
   endtask : pulse

endmodule : eba_core_model

// File: verification/eba_alu_tb_top.sv
// Purpose: Self-checking bench for the subtract, logic and compare datapath
// Assumes: Expected timing and flags are worked out here from the tables
// Notes:   Consecutive runs are back to back, start in the cycle after done

module eba_alu_tb_top;
   timeunit 1ns;
   timeprecision 1ns;

   logic mclk, resetn, start, data_in_hram, busy, done, illegal_q;
   logic write_back_q, carry_flag_q, aux_carry_flag_q, zero_flag_q;
   eba_pkg::eba_op_t op;
   eba_pkg::eba_form_t form;
   logic [2:0] reg_sel;
   logic [7:0] first_operand, second_operand, result_q;
   logic [3:0] read_waits;
   logic [1:0] instr_bytes_q;
   logic [4:0] instr_clocks_q;
   logic ecy = 1'b0, eac = 1'b0, ez = 1'b0;
   logic [7:0] eres = 8'h00;
   int n_errors = 0;
   int compares = 0;

   // ----------------------------------------------------------------
   // Clock, design and sequencer
   // ----------------------------------------------------------------
   initial
   begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end

   eba_alu uut (.mclk(mclk), .resetn(resetn), .start(start), .op(op), .form(form),
      .reg_sel(reg_sel), .first_operand(first_operand), .second_operand(second_operand),
      .data_in_hram(data_in_hram), .read_waits(read_waits), .busy(busy), .done(done),
      .illegal_q(illegal_q), .result_q(result_q), .write_back_q(write_back_q),
      .carry_flag_q(carry_flag_q), .aux_carry_flag_q(aux_carry_flag_q),
      .zero_flag_q(zero_flag_q), .instr_bytes_q(instr_bytes_q),
      .instr_clocks_q(instr_clocks_q));

   eba_core_model u_model (.mclk(mclk), .busy(busy), .done(done), .start(start),
      .op(op), .form(form), .reg_sel(reg_sel), .first_operand(first_operand),
      .second_operand(second_operand), .data_in_hram(data_in_hram),
      .read_waits(read_waits));

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      compares++;
      if (g !== e)
      begin
         n_errors++;
         $display("FAIL %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   function automatic int exp_clk(eba_pkg::eba_form_t f, logic h, logic [3:0] n);
      case (f)
         eba_pkg::EBA_FORM_SADDR_IMM: return h ? 6 : 8;
         eba_pkg::EBA_FORM_A_SADDR: return h ? 4 : 5;
         eba_pkg::EBA_FORM_A_PTR: return h ? 4 : 5 + n;
         eba_pkg::EBA_FORM_A_ABS, eba_pkg::EBA_FORM_A_PTR_BYTE,
         eba_pkg::EBA_FORM_A_PTR_B, eba_pkg::EBA_FORM_A_PTR_C: return h ? 8 : 9 + n;
         default: return 4;
      endcase
   endfunction : exp_clk

   function automatic int exp_bytes(eba_pkg::eba_form_t f);
      if (f == eba_pkg::EBA_FORM_A_PTR)
         return 1;
      if (f == eba_pkg::EBA_FORM_SADDR_IMM || f == eba_pkg::EBA_FORM_A_ABS)
         return 3;
      return 2;
   endfunction : exp_bytes

   // One instruction end to end; logic ops carry the old flags through d and hd
   task automatic run(input eba_pkg::eba_op_t o, input eba_pkg::eba_form_t f,
      input logic [2:0] r, input logic [7:0] a, input logic [7:0] b,
      input logic h, input logic [3:0] n);
      logic [8:0] d;
      logic [4:0] hd;
      int t;
      d = {1'b0, a} - {1'b0, b};
      hd = {1'b0, a[3:0]} - {1'b0, b[3:0]};
      if (o == eba_pkg::EBA_OP_SUBTRACT_BORROW_OP)
      begin
         d = d - {8'h00, ecy};
         hd = hd - {4'h0, ecy};
      end
      if (o == eba_pkg::EBA_OP_AND)
         d = {ecy, a & b};
      if (o == eba_pkg::EBA_OP_OR)
         d = {ecy, a | b};
      if (o == eba_pkg::EBA_OP_XOR)
         d = {ecy, a ^ b};
      if (o inside {eba_pkg::EBA_OP_AND, eba_pkg::EBA_OP_OR, eba_pkg::EBA_OP_XOR})
         hd = {eac, 4'h0};
      ecy = d[8];
      eac = hd[4];
      ez = (d[7:0] == 8'h00);
      if (o != eba_pkg::EBA_OP_CMP)
         eres = d[7:0];
      u_model.issue(o, f, r, a, b, h, n, t);
      chk("clocks seen", 8'(exp_clk(f, h, n)), 8'(t));
      @(negedge mclk);
      chk("instr_clocks_q", 8'(exp_clk(f, h, n)), {3'h0, instr_clocks_q});
      chk("instr_bytes_q", 8'(exp_bytes(f)), {6'h0, instr_bytes_q});
      chk("result_q", eres, result_q);
      chk("write_back_q", {7'h0, o != eba_pkg::EBA_OP_CMP}, {7'h0, write_back_q});
      chk("flags", {5'h0, ecy, eac, ez},
         {5'h0, carry_flag_q, aux_carry_flag_q, zero_flag_q});
   endtask : run

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   // Every form in both columns, waits varied, then the longest count
   task automatic test_timing();
      for (int i = 0; i < 10; i++)
         for (int h = 0; h < 2; h++)
            run(eba_pkg::EBA_OP_SUB, eba_pkg::eba_form_t'(i), 3'h2, 8'h10, 8'h01,
               h[0], 4'(i));
      run(eba_pkg::EBA_OP_SUB, eba_pkg::EBA_FORM_A_PTR_C, 3'h2, 8'h10, 8'h01, 1'b0,
         4'hF);
      run(eba_pkg::EBA_OP_SUB, eba_pkg::EBA_FORM_A_PTR, 3'h2, 8'h10, 8'h01, 1'b0,
         4'h3);
      $display("test timing finished");
   endtask : test_timing

   // Flag effects of each operation, including carry kept by logic ops
   task automatic test_arith();
      run(eba_pkg::EBA_OP_SUB, eba_pkg::EBA_FORM_A_IMM, 3'h2, 8'h00, 8'h01, 1'b1, 4'h0);
      run(eba_pkg::EBA_OP_AND, eba_pkg::EBA_FORM_A_REG, 3'h2, 8'hF0, 8'h0F, 1'b1, 4'h0);
      run(eba_pkg::EBA_OP_SUBTRACT_BORROW_OP, eba_pkg::EBA_FORM_REG_A, 3'h1, 8'h05, 8'h02,
         1'b1, 4'h0);
      run(eba_pkg::EBA_OP_OR, eba_pkg::EBA_FORM_A_SADDR, 3'h2, 8'h00, 8'h00, 1'b0, 4'h0);
      run(eba_pkg::EBA_OP_SUB, eba_pkg::EBA_FORM_A_ABS, 3'h2, 8'h05, 8'h06, 1'b0, 4'h2);
      run(eba_pkg::EBA_OP_XOR, eba_pkg::EBA_FORM_A_PTR, 3'h2, 8'hAA, 8'h55, 1'b1, 4'h0);
      run(eba_pkg::EBA_OP_SUBTRACT_BORROW_OP, eba_pkg::EBA_FORM_A_PTR_B, 3'h2, 8'h00, 8'h00,
         1'b0, 4'h2);
      run(eba_pkg::EBA_OP_CMP, eba_pkg::EBA_FORM_SADDR_IMM, 3'h2, 8'h03, 8'h03, 1'b0, 4'h0);
      run(eba_pkg::EBA_OP_CMP, eba_pkg::EBA_FORM_A_PTR_BYTE, 3'h2, 8'h01, 8'h02, 1'b0, 4'h4);
      $display("test arith finished");
   endtask : test_arith

   // Accumulator named by the accumulator-first register form is refused; start in the done cycle is lost
   task automatic test_refuse();
      int t;
      u_model.pulse(eba_pkg::EBA_OP_SUB, eba_pkg::EBA_FORM_A_REG,
         eba_pkg::EBA_REG_IDX_ACC);
      chk("illegal_q", 8'h01, {7'h0, illegal_q});
      chk("busy refused", 8'h00, {7'h0, busy});
      @(negedge mclk);
      chk("illegal_q end", 8'h00, {7'h0, illegal_q});
      u_model.issue(eba_pkg::EBA_OP_AND, eba_pkg::EBA_FORM_A_IMM, 3'h2, 8'hFF, 8'hFF, 1'b1,
         4'h0, t);
      eres = 8'hFF;
      ez = 1'b0;
      chk("clocks seen", 8'h04, 8'(t));
      u_model.pulse(eba_pkg::EBA_OP_CMP, eba_pkg::EBA_FORM_A_IMM, 3'h2);
      chk("busy after done", 8'h00, {7'h0, busy});
      // Let the dropped start pass an edge before the next request raises it
      @(negedge mclk);
      run(eba_pkg::EBA_OP_SUB, eba_pkg::EBA_FORM_A_REG, 3'h0, 8'h80, 8'h7F, 1'b1, 4'h0);
      $display("test refuse finished");
   endtask : test_refuse

   // ----------------------------------------------------------------
   // Verdict, watchdog and main sequence
   // ----------------------------------------------------------------
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : complete_run

   // Whole run is well under 2000 cycles; a hang stops here
   initial
   begin
      repeat (20000) @(posedge mclk);
      n_errors++;
      $display("watchdog expired");
      complete_run();
   end

   initial
   begin
      resetn = 1'b0;
      repeat (3) @(posedge mclk);
      @(negedge mclk);
      resetn = 1'b1;
      repeat (4) @(negedge mclk);
      test_timing();
      test_arith();
      test_refuse();
      complete_run();
   end

endmodule : eba_alu_tb_top
